// ===== rtl/ufc_map.vh
`ifndef UFC_MAP_VH
`define UFC_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define UFC_OFS_THRESH 8'h0F
`define UFC_OFS_FLOW 8'h13
`define UFC_OFS_RES1 8'h14
`define UFC_OFS_RES2 8'h15
`define UFC_OFS_PAU1 8'h16
`define UFC_OFS_PAU2 8'h17
`define UFC_OFS_MODE 8'h30
`define UFC_OFS_STAT 8'h31
`define UFC_OFS_MASK 8'h32
`define UFC_OFS_STATE 8'h33
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define UFC_FLOW_TXSEL_HI 7
`define UFC_FLOW_TXSEL_LO 6
`define UFC_FLOW_RXSEL_HI 5
`define UFC_FLOW_RXSEL_LO 4
`define UFC_FLOW_SWEN 3
`define UFC_FLOW_PINADDR 2
`define UFC_FLOW_ACTS 1
`define UFC_FLOW_ARTS 0
`define UFC_MODE_TXDIS 0
`define UFC_MODE_SPEC 1
`define UFC_MODE_RTS 2
`define UFC_ST_SPEC 0
`define UFC_ST_PAUSE 1
`define UFC_ST_RESUME 2
`define UFC_ST_CTS 7
`define UFC_RST_BYTE 8'h00
`define UFC_LVL_SHIFT 3
`endif

// ===== rtl/ufc_flow.v
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ufc_map.vh"

module ufc_flow (
	input wire CLK_SYS,
	input wire RST_N,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	input wire RX_CHAR_VALID,
	input wire [7:0] RX_CHAR,
	output reg RXQ_WR,
	output reg [7:0] RXQ_DATA,
	input wire [7:0] RXQ_LEVEL,
	input wire [3:0] GPIO_IN,
	input wire CTS_N,
	output reg RTS_N,
	output reg TX_ALLOW,
	output reg TX_FLOW_VALID,
	output reg [7:0] TX_FLOW_CHAR,
	input wire TX_FLOW_READY,
	output reg IRQ
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg [7:0] flow_control_config;
	reg [7:0] resume_char_first;
	reg [7:0] resume_char_second;
	reg [7:0] pause_char_first;
	reg [7:0] pause_char_second;
	reg [7:0] flow_threshold_config;
	reg [7:0] mode_ctrl;
	reg [7:0] irq_status;
	reg [7:0] irq_mask;
	reg cts_q;
	reg remote_paused;
	reg local_halted;
	reg pend_v;
	reg [7:0] pend;
	reg [1:0] tx_left;
	reg [7:0] tx_next;

	wire [1:0] tx_sel = flow_control_config[`UFC_FLOW_TXSEL_HI:`UFC_FLOW_TXSEL_LO];
	wire [1:0] rx_sel = flow_control_config[`UFC_FLOW_RXSEL_HI:`UFC_FLOW_RXSEL_LO];
	wire soft_en = flow_control_config[`UFC_FLOW_SWEN];
	wire pin_addr = flow_control_config[`UFC_FLOW_PINADDR];
	wire auto_cts = flow_control_config[`UFC_FLOW_ACTS];
	wire auto_rts = flow_control_config[`UFC_FLOW_ARTS];
	wire spec_en = mode_ctrl[`UFC_MODE_SPEC];
	wire tx_dis = mode_ctrl[`UFC_MODE_TXDIS];

	// ----------------------------------------
	// character set and roles
	// ----------------------------------------
	// pin-address mode replaces the stored low nibble for matching only
	wire [7:0] pause2_eff = pin_addr ? {pause_char_second[7:4], GPIO_IN} : pause_char_second;
	// both select bits set counts as double-character mode
	wire rx_dbl = (rx_sel == 2'b11);
	wire tx_dbl = (tx_sel == 2'b11);
	// double mode: the earlier byte on the line is the low byte, both ways
	wire [15:0] res16 = {resume_char_second, resume_char_first};
	wire [15:0] pau16 = {pause2_eff, pause_char_first};
	// first pair serves flow when soft flow is on, second pair only without detection
	wire flow_first = soft_en;
	wire flow_second = soft_en & ~spec_en;
	wire spec_first = spec_en & ~soft_en;
	wire spec_second = spec_en;
	wire cmp_first = rx_sel[1];
	wire cmp_second = rx_sel[0];

	// ----------------------------------------
	// receive comparison
	// ----------------------------------------
	// a pair match in double mode replaces the single-character compares
	reg hit_res_flow;
	reg hit_pau_flow;
	reg hit_spec;
	always @* begin
		hit_res_flow = 1'b0;
		hit_pau_flow = 1'b0;
		hit_spec = 1'b0;
		if (RX_CHAR_VALID) begin
			if (rx_dbl) begin
				// pair compare: previous byte low, current byte high
				if (pend_v && {RX_CHAR, pend} == res16) begin
					hit_res_flow = soft_en;
					hit_spec = ~soft_en & spec_en;
				end
				if (pend_v && {RX_CHAR, pend} == pau16) begin
					hit_pau_flow = soft_en;
					hit_spec = ~soft_en & spec_en;
				end
			end else begin
				if (cmp_first && RX_CHAR == resume_char_first) begin
					hit_res_flow = hit_res_flow | flow_first;
					hit_spec = hit_spec | spec_first;
				end
				if (cmp_first && RX_CHAR == pause_char_first) begin
					hit_pau_flow = hit_pau_flow | flow_first;
					hit_spec = hit_spec | spec_first;
				end
				if (cmp_second && RX_CHAR == resume_char_second) begin
					hit_res_flow = hit_res_flow | flow_second;
					hit_spec = hit_spec | spec_second;
				end
				if (cmp_second && RX_CHAR == pause2_eff) begin
					hit_pau_flow = hit_pau_flow | flow_second;
					hit_spec = hit_spec | spec_second;
				end
			end
		end
	end

	// flow characters are dropped only with soft flow and comparison both on
	wire drop = soft_en & (rx_sel != 2'b00) & (hit_res_flow | hit_pau_flow);

	// ----------------------------------------
	// receive queue feed
	// ----------------------------------------
	// double mode holds one byte back so a matched pair can be dropped whole
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			RXQ_WR <= 1'b0;
			RXQ_DATA <= `UFC_RST_BYTE;
			pend_v <= 1'b0;
			pend <= `UFC_RST_BYTE;
		end else begin
			RXQ_WR <= 1'b0;
			if (RX_CHAR_VALID && rx_dbl) begin
				if (drop) begin
					pend_v <= 1'b0;
				end else begin
					RXQ_WR <= pend_v;
					RXQ_DATA <= pend;
					pend <= RX_CHAR;
					pend_v <= 1'b1;
				end
			end else if (RX_CHAR_VALID) begin
				RXQ_WR <= ~drop;
				RXQ_DATA <= RX_CHAR;
			end else if (pend_v && !rx_dbl) begin
				RXQ_WR <= 1'b1; // flush held byte on mode change
				RXQ_DATA <= pend;
				pend_v <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// thresholds
	// ----------------------------------------
	// levels step by eight words and top out at 120
	// a halt field of zero makes the halt level always reached
	wire [7:0] halt_lvl = {1'b0, flow_threshold_config[3:0], 3'b000};
	wire [7:0] resume_lvl = {1'b0, flow_threshold_config[7:4], 3'b000};
	wire at_halt = (RXQ_LEVEL >= halt_lvl);
	wire at_resume = (RXQ_LEVEL <= resume_lvl);

	// ----------------------------------------
	// remote throttle and transmit permission
	// ----------------------------------------
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			remote_paused <= 1'b0;
			cts_q <= 1'b1;
			TX_ALLOW <= 1'b0;
		end else begin
			cts_q <= CTS_N;
			if (!soft_en) begin
				remote_paused <= 1'b0;
			end else if (hit_pau_flow) begin
				remote_paused <= 1'b1;
			end else if (hit_res_flow) begin
				remote_paused <= 1'b0;
			end
			// clear-to-send high stops the transmitter in auto mode
			TX_ALLOW <= ~tx_dis & ~(auto_cts & CTS_N) & ~remote_paused;
		end
	end

	// ----------------------------------------
	// request-to-send
	// ----------------------------------------
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			RTS_N <= 1'b1;
		end else if (auto_rts) begin
			if (!RTS_N && at_halt) begin
				RTS_N <= 1'b1;
			end else if (RTS_N && at_resume) begin
				RTS_N <= 1'b0;
			end
		end else begin
			RTS_N <= ~mode_ctrl[`UFC_MODE_RTS];
		end
	end

	// ----------------------------------------
	// local flow character sender
	// ----------------------------------------
	// tx_left counts characters still to offer after the current one
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			local_halted <= 1'b0;
			TX_FLOW_VALID <= 1'b0;
			TX_FLOW_CHAR <= `UFC_RST_BYTE;
			tx_left <= 2'd0;
			tx_next <= `UFC_RST_BYTE;
		end else if (TX_FLOW_VALID) begin
			if (TX_FLOW_READY) begin
				if (tx_left != 2'd0) begin
					TX_FLOW_CHAR <= tx_next;
					tx_left <= tx_left - 2'd1;
				end else begin
					TX_FLOW_VALID <= 1'b0;
				end
			end
		end else if (!soft_en || tx_sel == 2'b00) begin
			local_halted <= 1'b0;
		end else if (!local_halted && at_halt) begin
			local_halted <= 1'b1;
			TX_FLOW_VALID <= 1'b1;
			case (tx_sel)
				2'b10: begin
					TX_FLOW_CHAR <= pause_char_first;
				end
				2'b01: begin
					TX_FLOW_CHAR <= pause_char_second;
				end
				default: begin
					TX_FLOW_CHAR <= pause_char_first;
					tx_next <= pause_char_second;
					tx_left <= 2'd1;
				end
			endcase
		end else if (local_halted && at_resume) begin
			local_halted <= 1'b0;
			TX_FLOW_VALID <= 1'b1;
			case (tx_sel)
				2'b10: begin
					TX_FLOW_CHAR <= resume_char_first;
				end
				2'b01: begin
					TX_FLOW_CHAR <= resume_char_second;
				end
				default: begin
					TX_FLOW_CHAR <= resume_char_first;
					tx_next <= resume_char_second;
					tx_left <= 2'd1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// register writes and sticky status
	// ----------------------------------------
	// the sampler resets high, so a low pin at release reports one change
	wire cts_change = (CTS_N != cts_q);
	reg [7:0] set_bits;
	// one set vector so every event reaches status the same way
	always @* begin
		set_bits = 8'h00;
		set_bits[`UFC_ST_CTS] = cts_change;
		set_bits[`UFC_ST_SPEC] = hit_spec;
		set_bits[`UFC_ST_PAUSE] = hit_pau_flow;
		set_bits[`UFC_ST_RESUME] = hit_res_flow;
	end

	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			flow_control_config <= `UFC_RST_BYTE;
			resume_char_first <= `UFC_RST_BYTE;
			resume_char_second <= `UFC_RST_BYTE;
			pause_char_first <= `UFC_RST_BYTE;
			pause_char_second <= `UFC_RST_BYTE;
			flow_threshold_config <= `UFC_RST_BYTE;
			mode_ctrl <= `UFC_RST_BYTE;
			irq_status <= `UFC_RST_BYTE;
			irq_mask <= `UFC_RST_BYTE;
			IRQ <= 1'b0;
		end else begin
			// set wins over a write-one clear in the same cycle
			if (REG_WR && REG_ADDR == `UFC_OFS_STAT) begin
				irq_status <= (irq_status & ~REG_WDATA) | set_bits;
			end else begin
				irq_status <= irq_status | set_bits;
			end
			IRQ <= |(irq_status & irq_mask);
			if (REG_WR) begin
				case (REG_ADDR)
					`UFC_OFS_FLOW: flow_control_config <= REG_WDATA;
					`UFC_OFS_RES1: resume_char_first <= REG_WDATA;
					`UFC_OFS_RES2: resume_char_second <= REG_WDATA;
					`UFC_OFS_PAU1: pause_char_first <= REG_WDATA;
					`UFC_OFS_PAU2: pause_char_second <= REG_WDATA;
					`UFC_OFS_THRESH: flow_threshold_config <= REG_WDATA;
					`UFC_OFS_MODE: mode_ctrl <= {5'b00000, REG_WDATA[2:0]};
					`UFC_OFS_MASK: irq_mask <= REG_WDATA;
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	reg [7:0] next_rdata;
	always @* begin
		case (REG_ADDR)
			`UFC_OFS_FLOW: next_rdata = flow_control_config;
			`UFC_OFS_RES1: next_rdata = resume_char_first;
			`UFC_OFS_RES2: next_rdata = resume_char_second;
			`UFC_OFS_PAU1: next_rdata = pause_char_first;
			`UFC_OFS_PAU2: next_rdata = pause_char_second;
			`UFC_OFS_THRESH: next_rdata = flow_threshold_config;
			`UFC_OFS_MODE: next_rdata = mode_ctrl;
			`UFC_OFS_STAT: next_rdata = irq_status;
			`UFC_OFS_MASK: next_rdata = irq_mask;
			`UFC_OFS_STATE: next_rdata = {4'h0, cts_q, local_halted, remote_paused, pend_v};
			default: next_rdata = 8'h00;
		endcase
	end

	// read data stand for the one cycle after the strobe, zero otherwise
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else begin
			REG_RDATA <= REG_RD ? next_rdata : 8'h00;
		end
	end

endmodule // ufc_flow
`default_nettype wire

// ===== testbench/ufc_flow_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "ufc_map.vh"
// ----------------------------------------
// flow block checker
// ----------------------------------------
module ufc_flow_props (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic RX_CHAR_VALID,
	input wire logic [7:0] RX_CHAR,
	input wire logic RXQ_WR,
	input wire logic [7:0] RXQ_DATA,
	input wire logic [7:0] RXQ_LEVEL,
	input wire logic CTS_N,
	input wire logic RTS_N,
	input wire logic TX_ALLOW,
	input wire logic TX_FLOW_VALID,
	input wire logic [7:0] TX_FLOW_CHAR,
	input wire logic TX_FLOW_READY,
	input wire logic IRQ
);
	logic [7:0] sh [0:255];
	wire [7:0] fl = sh[`UFC_OFS_FLOW];
	wire [7:0] th = sh[`UFC_OFS_THRESH];
	wire [7:0] msk = sh[`UFC_OFS_MASK];
	wire [7:0] rx = sh[REG_ADDR];
	wire [7:0] hl = {1'b0, th[3:0], 3'h0};
	wire [7:0] rl = {1'b0, th[7:4], 3'h0};
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// shadow of host writes
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			for (int i = 0; i < 256; i++)
				sh[i] <= 8'h00;
		end else if (REG_WR) begin
			sh[REG_ADDR] <= REG_WDATA;
		end
	end
	flow_hold_a: assert property (TX_FLOW_VALID && !TX_FLOW_READY |=> TX_FLOW_VALID && $stable(TX_FLOW_CHAR))
		else $error("flow char left early");
	rd_back_a: assert property (REG_RD && REG_ADDR inside {8'h0F, [8'h13:8'h17], 8'h32} |=> REG_RDATA == $past(rx))
		else $error("readback differs");
	rd_idle_a: assert property (!REG_RD || REG_ADDR == 8'h20 |=> REG_RDATA == 8'h00)
		else $error("read data not idle");
	pass_through_a: assert property (RX_CHAR_VALID && !fl[3] && fl[5:4] != 2'h3 |=> RXQ_WR && RXQ_DATA == $past(RX_CHAR))
		else $error("char not queued");
	cts_gate_a: assert property ((fl[1] && CTS_N) [*3] |=> !TX_ALLOW)
		else $error("tx not held");
	cts_irq_a: assert property (msk[7] && CTS_N != $past(CTS_N) |-> ##[1:3] IRQ)
		else $error("cts change missed");
	rts_halt_a: assert property ((fl[0] && RXQ_LEVEL >= hl && RXQ_LEVEL > rl) [*2] |=> RTS_N)
		else $error("rts not raised");
	rts_resume_a: assert property ((fl[0] && RXQ_LEVEL <= rl && RXQ_LEVEL < hl) [*2] |=> !RTS_N)
		else $error("rts not lowered");
	irq_mask_a: assert property ((msk == 8'h00) [*2] |-> !IRQ)
		else $error("masked irq");
	cover property (TX_FLOW_VALID && TX_FLOW_READY);
	cover property (RXQ_WR);
	cover property (IRQ);
endmodule // ufc_flow_props
bind ufc_flow ufc_flow_props u_props (
	.CLK_SYS(CLK_SYS),
	.RST_N(RST_N),
	.REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR),
	.REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA),
	.RX_CHAR_VALID(RX_CHAR_VALID),
	.RX_CHAR(RX_CHAR),
	.RXQ_WR(RXQ_WR),
	.RXQ_DATA(RXQ_DATA),
	.RXQ_LEVEL(RXQ_LEVEL),
	.CTS_N(CTS_N),
	.RTS_N(RTS_N),
	.TX_ALLOW(TX_ALLOW),
	.TX_FLOW_VALID(TX_FLOW_VALID),
	.TX_FLOW_CHAR(TX_FLOW_CHAR),
	.TX_FLOW_READY(TX_FLOW_READY),
	.IRQ(IRQ)
);
`default_nettype wire

// ===== testbench/ufc_remote.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// remote serial station
// ----------------------------------------
module ufc_remote (
	input wire logic CLK_SYS,
	output logic RX_CHAR_VALID,
	output logic [7:0] RX_CHAR,
	input wire logic TX_FLOW_VALID,
	input wire logic [7:0] TX_FLOW_CHAR,
	output logic TX_FLOW_READY
);
	int stall;
	int wait_n;
	logic [7:0] got [$];
	// idle start
	initial begin
		RX_CHAR_VALID = 1'b0;
		RX_CHAR = 8'h00;
		TX_FLOW_READY = 1'b0;
		stall = 0;
		wait_n = 0;
	end
	// one character, then the line shows its inverse
	task send(input logic [7:0] c);
		@(posedge CLK_SYS);
		RX_CHAR_VALID <= 1'b1;
		RX_CHAR <= c;
		@(posedge CLK_SYS);
		RX_CHAR_VALID <= 1'b0;
		RX_CHAR <= ~c;
	endtask
	// take offered flow chars after a stall, in arrival order
	always @(posedge CLK_SYS) begin
		if (TX_FLOW_VALID && TX_FLOW_READY) begin
			got.push_back(TX_FLOW_CHAR);
		end
		wait_n <= (TX_FLOW_VALID && !TX_FLOW_READY) ? wait_n + 1 : 0;
		TX_FLOW_READY <= TX_FLOW_VALID && !TX_FLOW_READY && wait_n >= stall;
	end
endmodule // ufc_remote
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ufc_map.vh"
// ----------------------------------------
// flow block bench
// ----------------------------------------
module tb;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] REG_ADDR;
	logic [7:0] REG_WDATA;
	logic REG_WR;
	logic REG_RD;
	logic [7:0] RXQ_LEVEL;
	logic [3:0] GPIO_IN;
	logic CTS_N;
	wire RX_CHAR_VALID, RXQ_WR, RTS_N, TX_ALLOW, TX_FLOW_VALID, TX_FLOW_READY, IRQ;
	wire [7:0] REG_RDATA, RX_CHAR, RXQ_DATA, TX_FLOW_CHAR;
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [7:0] rq [$];
	localparam logic [23:0] ROWS [0:9] = '{24'h0F5A5A, 24'h13F0F0, 24'h141111, 24'h152222, 24'h161313,
		24'h17A5A5, 24'h30FF07, 24'h328181, 24'h31FF00, 24'h205A00};
	localparam logic [7:0] SELS [0:2] = '{8'h88, 8'h48, 8'hC8};
	localparam logic [7:0] EXP [0:7] = '{8'h13, 8'h11, 8'hA5, 8'h22, 8'h13, 8'hA5, 8'h11, 8'h22};
	localparam logic [7:0] LV [0:3] = '{8'h17, 8'h18, 8'h11, 8'h10};
	localparam logic [7:0] RT [0:3] = '{8'h00, 8'h01, 8'h01, 8'h00};
	always #5 CLK_SYS = ~CLK_SYS;
	ufc_flow dut (
		.CLK_SYS(CLK_SYS),
		.RST_N(RST_N),
		.REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR),
		.REG_RD(REG_RD),
		.REG_RDATA(REG_RDATA),
		.RX_CHAR_VALID(RX_CHAR_VALID),
		.RX_CHAR(RX_CHAR),
		.RXQ_WR(RXQ_WR),
		.RXQ_DATA(RXQ_DATA),
		.RXQ_LEVEL(RXQ_LEVEL),
		.GPIO_IN(GPIO_IN),
		.CTS_N(CTS_N),
		.RTS_N(RTS_N),
		.TX_ALLOW(TX_ALLOW),
		.TX_FLOW_VALID(TX_FLOW_VALID),
		.TX_FLOW_CHAR(TX_FLOW_CHAR),
		.TX_FLOW_READY(TX_FLOW_READY),
		.IRQ(IRQ)
	);
	ufc_remote u_rem (
		.CLK_SYS(CLK_SYS),
		.RX_CHAR_VALID(RX_CHAR_VALID),
		.RX_CHAR(RX_CHAR),
		.TX_FLOW_VALID(TX_FLOW_VALID),
		.TX_FLOW_CHAR(TX_FLOW_CHAR),
		.TX_FLOW_READY(TX_FLOW_READY)
	);
	// record queue writes
	always @(posedge CLK_SYS) begin
		if (RXQ_WR === 1'b1) begin
			rq.push_back(RXQ_DATA);
		end
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1;
		chk(REG_RDATA, e);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		n_mismatch++;
		complete_run;
	end
	// main sequence
	initial begin
		REG_ADDR <= 8'h00;
		REG_WDATA <= 8'h00;
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		RXQ_LEVEL <= 8'h00;
		GPIO_IN <= 4'h0;
		CTS_N <= 1'b1;
		repeat (16) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		cyc(2);
		chk({7'h00, TX_ALLOW}, 8'h01);
		for (int i = 0; i < 10; i++) begin
			rd(ROWS[i][23:16], 8'h00);
			wr(ROWS[i][23:16], ROWS[i][15:8]);
			rd(ROWS[i][23:16], ROWS[i][7:0]);
		end
		$display("register rows done");
		wr(`UFC_OFS_MODE, 8'h00);
		wr(`UFC_OFS_FLOW, 8'h28);
		u_rem.send(8'h41);
		u_rem.send(8'h13);
		cyc(3);
		chk({7'h00, TX_ALLOW}, 8'h00);
		u_rem.send(8'h11);
		cyc(3);
		chk({7'h00, TX_ALLOW}, 8'h01);
		chk(8'(rq.size()), 8'h01);
		chk(rq[0], 8'h41);
		$display("filter test done");
		wr(`UFC_OFS_FLOW, 8'h38);
		u_rem.send(8'h41);
		u_rem.send(8'h13);
		u_rem.send(8'hA5);
		cyc(3);
		chk({7'h00, TX_ALLOW}, 8'h00);
		u_rem.send(8'h11);
		u_rem.send(8'h22);
		cyc(3);
		chk({7'h00, TX_ALLOW}, 8'h01);
		chk(8'(rq.size()), 8'h02);
		chk(rq[1], 8'h41);
		$display("pair filter test done");
		wr(`UFC_OFS_MODE, 8'h02);
		wr(`UFC_OFS_FLOW, 8'h10);
		wr(`UFC_OFS_MASK, 8'h01);
		wr(`UFC_OFS_STAT, 8'hFF);
		u_rem.send(8'hA5);
		cyc(3);
		chk({6'h00, IRQ, TX_ALLOW}, 8'h03);
		chk(rq[2], 8'hA5);
		wr(`UFC_OFS_STAT, 8'h01);
		cyc(2);
		chk({7'h00, IRQ}, 8'h00);
		u_rem.send(8'h22);
		cyc(3);
		chk({7'h00, IRQ}, 8'h01);
		$display("detect test done");
		@(posedge CLK_SYS);
		GPIO_IN <= 4'h3;
		wr(`UFC_OFS_FLOW, 8'h14);
		rd(`UFC_OFS_PAU2, 8'hA5);
		wr(`UFC_OFS_STAT, 8'hFF);
		u_rem.send(8'hA5);
		cyc(3);
		chk({7'h00, IRQ}, 8'h00);
		u_rem.send(8'hA3);
		cyc(3);
		chk({7'h00, IRQ}, 8'h01);
		$display("pin address test done");
		wr(`UFC_OFS_MODE, 8'h00);
		wr(`UFC_OFS_MASK, 8'h00);
		wr(`UFC_OFS_THRESH, 8'h23);
		for (int k = 0; k < 3; k++) begin
			u_rem.stall = k * 2;
			wr(`UFC_OFS_FLOW, SELS[k]);
			@(posedge CLK_SYS);
			RXQ_LEVEL <= 8'h18;
			cyc(20);
			@(posedge CLK_SYS);
			RXQ_LEVEL <= 8'h10;
			cyc(20);
		end
		chk(8'(u_rem.got.size()), 8'h08);
		for (int i = 0; i < 8; i++)
			chk(u_rem.got[i], EXP[i]);
		$display("sender test done");
		wr(`UFC_OFS_FLOW, 8'h01);
		cyc(3);
		chk({7'h00, RTS_N}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			@(posedge CLK_SYS);
			RXQ_LEVEL <= LV[i];
			cyc(3);
			chk({7'h00, RTS_N}, RT[i]);
		end
		$display("rts test done");
		wr(`UFC_OFS_MODE, 8'h01);
		wr(`UFC_OFS_FLOW, 8'h02);
		wr(`UFC_OFS_MODE, 8'h00);
		wr(`UFC_OFS_MASK, 8'h80);
		wr(`UFC_OFS_STAT, 8'hFF);
		cyc(3);
		chk({6'h00, IRQ, TX_ALLOW}, 8'h00);
		@(posedge CLK_SYS);
		CTS_N <= 1'b0;
		cyc(4);
		chk({6'h00, IRQ, TX_ALLOW}, 8'h03);
		$display("cts test done");
		@(posedge CLK_SYS);
		RST_N <= 1'b0;
		cyc(2);
		chk({5'h00, RTS_N, IRQ, TX_ALLOW}, 8'h04);
		@(posedge CLK_SYS);
		RST_N <= 1'b1;
		cyc(2);
		rd(`UFC_OFS_STAT, 8'h80);
		rd(`UFC_OFS_FLOW, 8'h00);
		$display("reset test done");
		complete_run;
	end
endmodule // tb
`default_nettype wire
